// file: rf_bias_cfg.svh
`ifndef RF_BIAS_CFG_SVH
`define RF_BIAS_CFG_SVH

// ----------------------------------------
// Bus geometry
// ----------------------------------------
`define WB_ADR_W 4
`define WB_DAT_W 32
`define WB_SEL_W 4

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define CTRL_ADDR 4'h0
`define STAT_ADDR 4'h4
`define IDENT_ADDR 4'h8

// ----------------------------------------
// Control register fields and reset
// ----------------------------------------
`define PORT_MODE_BIT 12
`define POLARITY_BIT 13
`define ENABLE_BIT 14
`define CFG_LANE 1
`define CTRL_RESET 32'h0000_0000
`define READ_ZERO 32'h0000_0000
`define IDENT_DEFAULT 32'h0000_5A01

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define STAT_LEVEL_BIT 0
`define STAT_DRIVE_BIT 1
`define STAT_MODE_LSB 4

// ----------------------------------------
// Radio mode codes
// ----------------------------------------
`define MODE_W 3
`define MODE_OFF 3'h0
`define MODE_HIBERNATE 3'h1
`define MODE_DOZE 3'h2
`define MODE_IDLE 3'h3
`define MODE_RX 3'h4
`define MODE_TX 3'h5

// ----------------------------------------
// Pin stage one-hot state codes
// ----------------------------------------
`define PIN_HIZ 3'h1
`define PIN_LOW 3'h2
`define PIN_HIGH 3'h4

`endif

// file: rf_bias_pkg.sv
`include "rf_bias_cfg.svh"

package rf_bias_pkg;

	// ----------------------------------------
	// Radio state from the sequencer
	// ----------------------------------------
	typedef enum logic [`MODE_W-1:0] {
		MODE_OFF = `MODE_OFF,
		MODE_HIBERNATE = `MODE_HIBERNATE,
		MODE_DOZE = `MODE_DOZE,
		MODE_IDLE = `MODE_IDLE,
		MODE_RX = `MODE_RX,
		MODE_TX = `MODE_TX
	} radio_mode_type;

	// ----------------------------------------
	// Output pin stage states
	// ----------------------------------------
	typedef enum logic [2:0] {
		PIN_HIZ = `PIN_HIZ,
		PIN_LOW = `PIN_LOW,
		PIN_HIGH = `PIN_HIGH
	} pin_state_type;

	// ----------------------------------------
	// Configuration bits
	// ----------------------------------------
	typedef struct packed {
		logic bias_out_enable;
		logic bias_polarity_invert;
		logic port_select_mode;
	} bias_cfg_type;

	// ----------------------------------------
	// Wishbone request from the master
	// ----------------------------------------
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [`WB_ADR_W-1:0] adr;
		logic [`WB_SEL_W-1:0] sel;
		logic [`WB_DAT_W-1:0] dat;
	} wb_req_type;

endpackage : rf_bias_pkg

// file: bias_level_decode.sv
`timescale 1ns/1ps

module bias_level_decode
	import rf_bias_pkg::*;
(
	input bias_cfg_type cfg,
	input radio_mode_type radio_mode,
	output logic drive,
	output logic level
);

	// ----------------------------------------
	// Pin decode from settings and radio state
	// ----------------------------------------
	// Off and unknown codes float the pin: level is held at zero there
	always_comb begin
		drive = 1'b0;
		level = 1'b0;
		if (cfg.bias_out_enable) begin
			case (radio_mode)
				MODE_TX: begin
					drive = 1'b1;
					// Single port ignores invert entirely
					level = cfg.port_select_mode ? 1'b1
						: ~cfg.bias_polarity_invert;
				end
				MODE_RX: begin
					drive = 1'b1;
					level = cfg.port_select_mode ? 1'b0
						: cfg.bias_polarity_invert;
				end
				MODE_IDLE, MODE_DOZE, MODE_HIBERNATE: begin
					drive = 1'b1;
					level = 1'b0;
				end
				default: begin
					drive = 1'b0;
					level = 1'b0;
				end
			endcase
		end
	end

endmodule : bias_level_decode

// file: wb_slave_port.sv
`timescale 1ns/1ps
`include "rf_bias_cfg.svh"

module wb_slave_port
	import rf_bias_pkg::*;
(
	input logic clk_sys,
	input logic rst_n,
	input wb_req_type wb_req,
	input logic [`WB_DAT_W-1:0] rd_word,
	output logic ack_q,
	output logic [`WB_DAT_W-1:0] dat_q,
	output logic wr_stb
);

	logic ack_d;
	logic [`WB_DAT_W-1:0] dat_d;
	logic req_live;

	// ----------------------------------------
	// Single-wait answer, one-cycle ack
	// ----------------------------------------
	// Read word is captured as ack rises; address is already stable
	always_comb begin
		req_live = wb_req.cyc & wb_req.stb & ~ack_q;
		ack_d = req_live;
		dat_d = req_live ? rd_word : dat_q;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			dat_q <= `READ_ZERO;
		end else begin
			ack_q <= ack_d;
			dat_q <= dat_d;
		end
	end

	// Writes commit on the edge where the master sees ack
	assign wr_stb = ack_q & wb_req.cyc & wb_req.stb & wb_req.we;

endmodule : wb_slave_port

// file: rf_bias_ctrl.sv
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/1ps
// Contract
// - Pin is driven only with enable set; otherwise floats in powered states.
// - Enabled level follows port mode first, then transmit or receive.
// - Single port mode ignores the polarity invert bit.
// - Single port, enabled: high in transmit, low in receive.
// - Dual port: invert picks transmit level, receive is the opposite.
// - Dual, not inverted: TX high, RX low; inverted: TX low, RX high.
// - Enabled and idle, doze or hibernate: pin driven low.
// - Enable lives at control bit 14, resets to zero.
// - Port mode at bit 12, resets zero (dual); one selects single.
// - Invert at bit 13, resets zero; matters only dual and enabled.
`include "rf_bias_cfg.svh"

module rf_bias_ctrl
	import rf_bias_pkg::*;
#(
	parameter logic [`WB_DAT_W-1:0] IDENT_VALUE = `IDENT_DEFAULT // Arbitrary
)
(
	input logic clk_sys,
	input logic rst_n,
	input wb_req_type wb_req,
	output logic [`WB_DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input radio_mode_type radio_mode,
	output logic rf_bias_ctrl_out,
	output logic rf_bias_ctrl_oe_n
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	bias_cfg_type cfg_q;
	bias_cfg_type cfg_d;
	pin_state_type pin_q;
	pin_state_type pin_d;
	logic out_q;
	logic out_d;
	logic oe_n_q;
	logic oe_n_d;
	logic dec_drive;
	logic dec_level;
	logic wr_stb;
	logic wr_ctrl;
	logic [`WB_DAT_W-1:0] rd_word;

	// Checks share one clock and sit out reset; declared before any use
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	wb_slave_port u_port (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.wb_req(wb_req),
		.rd_word(rd_word),
		.ack_q(wb_ack_o),
		.dat_q(wb_dat_o),
		.wr_stb(wr_stb)
	);

	// Ack only answers a live request, never on its own
	ack_answers_req_a: assert property (
		$rose(wb_ack_o) |-> $past(wb_req.cyc && wb_req.stb)
	) else $error("ack raised without a request");

	// Read word stands still between requests
	dat_hold_a: assert property (
		!(wb_req.cyc && wb_req.stb) |=> $stable(wb_dat_o)
	) else $error("read data moved without a request");

	// Byte lane 1 carries all three bits; other lanes are ignored
	assign wr_ctrl = wr_stb & (wb_req.adr == `CTRL_ADDR)
		& wb_req.sel[`CFG_LANE];

	// Lane 1 clear: the write is acked but the bits stay put
	masked_lane_a: assert property (
		wr_stb && !wb_req.sel[`CFG_LANE] |=> $stable(cfg_q)
	) else $error("masked write changed configuration");

	// Settings move only at the ack edge of a write cycle
	write_at_ack_a: assert property (
		!wb_ack_o |=> $stable(cfg_q)
	) else $error("configuration changed outside an ack");

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	// Unmapped addresses still ack and read as zero
	always_comb begin
		rd_word = `READ_ZERO;
		case (wb_req.adr)
			`CTRL_ADDR: begin
				rd_word[`ENABLE_BIT] = cfg_q.bias_out_enable;
				rd_word[`POLARITY_BIT] = cfg_q.bias_polarity_invert;
				rd_word[`PORT_MODE_BIT] = cfg_q.port_select_mode;
			end
			`STAT_ADDR: begin
				rd_word[`STAT_LEVEL_BIT] = out_q;
				rd_word[`STAT_DRIVE_BIT] = ~oe_n_q;
				rd_word[`STAT_MODE_LSB +: `MODE_W] = radio_mode;
			end
			`IDENT_ADDR: begin
				rd_word = IDENT_VALUE;
			end
			default: begin
				rd_word = `READ_ZERO;
			end
		endcase
	end

	// Control readback shows the three stored bits
	ctrl_readback_a: assert property (
		wb_req.cyc && wb_req.stb && !wb_ack_o
		&& wb_req.adr == `CTRL_ADDR
		|=> wb_dat_o[`ENABLE_BIT] == $past(cfg_q.bias_out_enable)
		&& wb_dat_o[`POLARITY_BIT]
		== $past(cfg_q.bias_polarity_invert)
		&& wb_dat_o[`PORT_MODE_BIT] == $past(cfg_q.port_select_mode)
	) else $error("control readback wrong");

	// Status is a snapshot of the pin and radio state at capture
	status_read_a: assert property (
		wb_req.cyc && wb_req.stb && !wb_ack_o
		&& wb_req.adr == `STAT_ADDR
		|=> wb_dat_o[`STAT_DRIVE_BIT] == !$past(oe_n_q)
		&& wb_dat_o[`STAT_LEVEL_BIT] == $past(out_q)
		&& wb_dat_o[`STAT_MODE_LSB +: `MODE_W] == $past(radio_mode)
	) else $error("status readback wrong");

	// Identity word is fixed by the parameter
	ident_read_a: assert property (
		wb_req.cyc && wb_req.stb && !wb_ack_o
		&& wb_req.adr == `IDENT_ADDR
		|=> wb_dat_o == IDENT_VALUE
	) else $error("identity readback wrong");

	// Holes in the map read as zero so software sees no stale data
	unmapped_zero_a: assert property (
		wb_req.cyc && wb_req.stb && !wb_ack_o
		&& wb_req.adr != `CTRL_ADDR && wb_req.adr != `STAT_ADDR
		&& wb_req.adr != `IDENT_ADDR
		|=> wb_dat_o == `READ_ZERO
	) else $error("unmapped address read nonzero");

	// ----------------------------------------
	// Configuration register
	// ----------------------------------------
	always_comb begin
		cfg_d = cfg_q;
		if (wr_ctrl) begin
			cfg_d.bias_out_enable = wb_req.dat[`ENABLE_BIT];
			cfg_d.bias_polarity_invert = wb_req.dat[`POLARITY_BIT];
			cfg_d.port_select_mode = wb_req.dat[`PORT_MODE_BIT];
		end
	end

	// All three bits clear: dual port, not inverted, pin floating
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= '0;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// ----------------------------------------
	// Level decode
	// ----------------------------------------
	bias_level_decode u_decode (
		.cfg(cfg_q),
		.radio_mode(radio_mode),
		.drive(dec_drive),
		.level(dec_level)
	);

	// ----------------------------------------
	// Pin stage
	// ----------------------------------------
	// One register stage so the pad sees no decode glitches
	always_comb begin
		case ({dec_drive, dec_level})
			2'b11: pin_d = PIN_HIGH;
			2'b10: pin_d = PIN_LOW;
			default: pin_d = PIN_HIZ;
		endcase
		case (pin_d)
			PIN_HIGH: begin
				out_d = 1'b1;
				oe_n_d = 1'b0;
			end
			PIN_LOW: begin
				out_d = 1'b0;
				oe_n_d = 1'b0;
			end
			PIN_HIZ: begin
				out_d = 1'b0;
				oe_n_d = 1'b1;
			end
			default: begin
				out_d = 1'b0;
				oe_n_d = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_q <= PIN_HIZ;
			out_q <= 1'b0;
			oe_n_q <= 1'b1;
		end else begin
			pin_q <= pin_d;
			out_q <= out_d;
			oe_n_q <= oe_n_d;
		end
	end

	assign rf_bias_ctrl_out = out_q;
	assign rf_bias_ctrl_oe_n = oe_n_q;

	// State, level and enable registers must tell one story
	pin_coherent_a: assert property (
		$onehot(pin_q) && oe_n_q == (pin_q == PIN_HIZ)
		&& out_q == (pin_q == PIN_HIGH)
	) else $error("pin stage registers disagree");

	// Single port receive sits at ground whatever invert holds
	single_rx_low_a: assert property (
		cfg_q.bias_out_enable && cfg_q.port_select_mode
		&& radio_mode == MODE_RX |=> !oe_n_q && !out_q
	) else $error("single port receive not low");

	// Codes past transmit are treated like off: pin floats
	bad_code_floats_a: assert property (
		radio_mode > `MODE_TX |=> oe_n_q
	) else $error("pin driven for an unused radio code");

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	disabled_floats_a: assert property (
		!cfg_q.bias_out_enable |=> oe_n_q && pin_q == PIN_HIZ
	) else $error("pin driven while disabled");

	single_tx_high_a: assert property (
		cfg_q.bias_out_enable && cfg_q.port_select_mode
		&& radio_mode == MODE_TX |=> !oe_n_q && out_q
	) else $error("single port transmit not high");

	single_no_invert_a: assert property (
		cfg_q.bias_out_enable && cfg_q.port_select_mode
		&& radio_mode == MODE_RX
		&& $changed(cfg_q.bias_polarity_invert)
		|=> !oe_n_q && !out_q
	) else $error("invert changed single port level");

	dual_tx_sense_a: assert property (
		cfg_q.bias_out_enable && !cfg_q.port_select_mode
		&& radio_mode == MODE_TX
		|=> !oe_n_q && out_q == !$past(cfg_q.bias_polarity_invert)
	) else $error("dual port transmit level wrong");

	dual_rx_opposite_a: assert property (
		cfg_q.bias_out_enable && !cfg_q.port_select_mode
		&& radio_mode == MODE_RX
		|=> !oe_n_q && out_q == $past(cfg_q.bias_polarity_invert)
	) else $error("dual port receive level wrong");

	quiet_low_a: assert property (
		cfg_q.bias_out_enable && (radio_mode == MODE_IDLE
		|| radio_mode == MODE_DOZE || radio_mode == MODE_HIBERNATE)
		|=> !oe_n_q && !out_q
	) else $error("quiet state not driven low");

	enable_bit_a: assert property (
		wr_ctrl |=> cfg_q.bias_out_enable == $past(wb_req.dat[`ENABLE_BIT])
	) else $error("enable not taken from bit 14");

	mode_bit_a: assert property (
		wr_ctrl |=> cfg_q.port_select_mode
		== $past(wb_req.dat[`PORT_MODE_BIT])
	) else $error("port mode not taken from bit 12");

	invert_bit_a: assert property (
		wr_ctrl |=> cfg_q.bias_polarity_invert
		== $past(wb_req.dat[`POLARITY_BIT])
	) else $error("invert not taken from bit 13");

	cfg_hold_a: assert property (
		!wr_ctrl |=> $stable(cfg_q)
	) else $error("configuration changed without a write");

	off_floats_a: assert property (
		radio_mode == MODE_OFF ##1 radio_mode == MODE_OFF |-> oe_n_q
	) else $error("pin driven while radio off");

	ack_pulse_a: assert property (
		wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o
	) else $error("ack not a single cycle pulse");

endmodule : rf_bias_ctrl

// file: rf_bias_load.sv
`timescale 1ns/1ps
// ----------------------------------------
// Far-side load on the bias pin
// ----------------------------------------
module rf_bias_load (
	input wire logic clk_sys,
	input wire logic pin_out,
	input wire logic pin_oe_n,
	output logic wire_level,
	output logic driven
);
	logic last_q;

	// No pull on the node: a floating pin shows the inverse of the last
	// driven level, so a stale value can never pass for a drive
	assign driven = !pin_oe_n;
	assign wire_level = driven ? pin_out : ~last_q;

	// Remember the last driven level
	always_ff @(posedge clk_sys) begin
		if (driven)
			last_q <= pin_out;
	end
endmodule : rf_bias_load

// file: tb_rf_bias_ctrl.sv
`timescale 1ns/1ps
`include "rf_bias_cfg.svh"
module tb_rf_bias_ctrl
	import rf_bias_pkg::*;
;
	logic clk_sys = 0;
	logic rst_n = 0;
	wb_req_type req = '0;
	logic [31:0] dat_o, rd;
	logic ack_o, out, oe_n, lvl, drv;
	radio_mode_type radio_mode = MODE_OFF;
	int num_errors = 0;
	int check_count = 0;

	rf_bias_ctrl uut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_req(req),
		.wb_dat_o(dat_o), .wb_ack_o(ack_o), .radio_mode(radio_mode),
		.rf_bias_ctrl_out(out), .rf_bias_ctrl_oe_n(oe_n));
	rf_bias_load load (.clk_sys(clk_sys), .pin_out(out), .pin_oe_n(oe_n),
		.wire_level(lvl), .driven(drv));

	// ----------------------------------------
	// Clock, compare, bus and verdict helpers
	// ----------------------------------------
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// Classic cycle; holds until ack is seen at a rising edge, then
	// takes the data and releases at that same edge
	task automatic wb(input logic we, input logic [3:0] adr,
		input logic [3:0] sel, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_sys);
		req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: d};
		do
			@(posedge clk_sys);
		while (ack_o !== 1'b1);
		r = dat_o;
		req <= '0;
	endtask : wb

	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish

	// Expected {driving, level}; c is {enable, invert, single}
	function automatic logic [1:0] exp_pin(logic [2:0] c, logic [2:0] m);
		if (!c[2] || m == 0 || m > 5)
			return 2'b00;
		if (m < 4)
			return 2'b10;
		return {1'b1, c[0] ? m[0] : m[0] ^ c[1]};
	endfunction : exp_pin

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		logic [1:0] e;
		logic [2:0] m;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1;
		radio_mode <= MODE_TX;
		wb(0, 4'h0, 4'hF, 0, rd);
		check(rd, 0);
		check({31'h0, drv}, 0);
		$display("reset test done");
		// Lane 1 masked and unmapped writes must not land
		wb(1, 4'h0, 4'hD, 32'h7000, rd);
		wb(1, 4'hC, 4'hF, 32'h7000, rd);
		wb(0, 4'hC, 4'hF, 0, rd);
		check(rd, 0);
		wb(0, 4'h8, 4'hF, 0, rd);
		check(rd, `IDENT_DEFAULT);
		wb(0, 4'h0, 4'hF, 0, rd);
		check(rd, 0);
		$display("bus test done");
		for (int c = 0; c < 8; c++) begin
			wb(1, 4'h0, 4'hF, c << 12, rd);
			wb(0, 4'h0, 4'hF, 0, rd);
			check(rd, c << 12);
			for (int k = 0; k < 8; k++) begin
				m = k[2:0];
				e = exp_pin(c[2:0], m);
				@(posedge clk_sys);
				radio_mode <= radio_mode_type'(m);
				repeat (2) @(posedge clk_sys);
				@(negedge clk_sys);
				check({31'h0, drv}, e[1]);
				if (e[1])
					check({31'h0, lvl}, e[0]);
				wb(0, 4'h4, 4'hF, 0, rd);
				check(rd & 32'h73, {m, 2'h0, e});
			end
		end
		$display("pin table test done");
		// Invert flipped under single port receive must leave the pin low
		wb(1, 4'h0, 4'hF, 32'h5000, rd);
		@(posedge clk_sys);
		radio_mode <= MODE_RX;
		wb(1, 4'h0, 4'hF, 32'h7000, rd);
		repeat (2) @(negedge clk_sys);
		check({31'h0, drv}, 1);
		check({31'h0, lvl}, 0);
		$display("single port invert test done");
		tally_and_finish();
	end

	// Watchdog well past the under five hundred cycles the tests need
	initial begin
		#3000000;
		num_errors++;
		tally_and_finish();
	end
endmodule : tb_rf_bias_ctrl
